// ### rtl/ccm_channel.sv
// Capture/compare channel of the counter array with shared mode decode
`timescale 1ns/10ps
`default_nettype none
`include "ccm_params.svh"
module ccm_channel
(
   input  wire logic          i_clock,
   input  wire logic          i_rstn,
   input  wire logic [15:0]   i_count,
   input  wire logic          i_count_en,
   input  wire ccm_pkg::ccm_sfr_t i_sfr,
   input  wire logic          i_io,
   output logic               o_io,
   output logic               o_io_oe,
   output ccm_pkg::ccm_rd_t   o_rd,
   output logic               o_event_flag,
   output logic               o_ovf_flag,
   output logic               o_irq
);
   import ccm_pkg::*;

   //------------------------------------------------------------
   // Registers
   //------------------------------------------------------------
   logic [7:0]  mode_r,  mode_nxt;
   logic [7:0]  pwm_r,   pwm_nxt;
   logic [7:0]  cpl_r,   cpl_nxt;
   logic [7:0]  cph_r,   cph_nxt;
   logic [7:0]  rll_r,   rll_nxt;
   logic [7:0]  rlh_r,   rlh_nxt;
   logic        ev_r,    ev_nxt;
   logic        ovf_r,   ovf_nxt;
   logic        out_r,   out_nxt;
   logic [2:0]  sync_r,  sync_nxt;
   logic        lvl_r,   lvl_nxt;
   ccm_mode_t   mode_sel;
   logic [15:0] cmp;
   logic [15:0] mask;
   logic [7:0]  freq_sum;
   logic        ecom;
   logic        view;
   logic        stable;
   logic        rise;
   logic        fall;
   logic        edge_hit;
   logic        full_match;
   logic        low_match;
   logic        n_match;
   logic        ovf8;
   logic        ovf_n;
   logic        ovf16;
   logic        quiet;

   //------------------------------------------------------------
   // Mode decode
   //------------------------------------------------------------
   // Wide select outranks the length field, so 16-bit PWM ignores it
   always_comb
   begin
      if (mode_r[`CCM_M_PWM])
      begin
         if (mode_r[`CCM_M_WIDE])
            mode_sel = CCM_PWM16;
         else if (mode_r[`CCM_M_TOG])
            mode_sel = CCM_FREQ;
         else if (pwm_r[`CCM_P_LEN_HI:`CCM_P_LEN_LO] == `CCM_LEN_8)
            mode_sel = CCM_PWM8;
         else
            mode_sel = CCM_PWM_ENABLE;
      end
      else if (mode_r[`CCM_M_TOG])
         mode_sel = CCM_HSO;
      else if (mode_r[`CCM_M_MATCH])
         mode_sel = CCM_TIMER;
      else if (mode_r[`CCM_M_RISE] || mode_r[`CCM_M_FALL])
         mode_sel = CCM_CAPT;
      else
         mode_sel = CCM_IDLE;
   end

   // Comparator terms, sampled only when the counter advances
   always_comb
   begin
      case (pwm_r[`CCM_P_LEN_HI:`CCM_P_LEN_LO])
         `CCM_LEN_8:  mask = `CCM_MASK_8;
         `CCM_LEN_9:  mask = `CCM_MASK_9;
         `CCM_LEN_10: mask = `CCM_MASK_10;
         default:     mask = `CCM_MASK_11;
      endcase
   end
   assign cmp        = {cph_r, cpl_r};
   assign ecom       = mode_r[`CCM_M_ECOM];
   assign view       = pwm_r[`CCM_P_VIEW];
   assign freq_sum   = cpl_r + cph_r;                         // Wraps mod 256
   assign full_match = i_count_en && (i_count == cmp);
   assign low_match  = i_count_en && (i_count[7:0] == cpl_r);
   assign n_match    = i_count_en && ((i_count & mask) == (cmp & mask));
   assign ovf8       = i_count_en && (i_count[7:0] == `CCM_BYTE_ONES);
   assign ovf_n      = i_count_en && ((i_count & mask) == mask);
   assign ovf16      = i_count_en && (i_count == `CCM_WORD_ONES);
   assign quiet      = !(i_sfr.wr_mode || i_sfr.wr_pwm || i_sfr.wr_low || i_sfr.wr_high);

   //------------------------------------------------------------
   // Io line synchroniser and edge filter
   //------------------------------------------------------------
   // Only stages two and three are compared; stage one may be metastable
   always_comb
   begin
      sync_nxt = {sync_r[1:0], i_io};
      stable   = (sync_r[1] == sync_r[2]);
      lvl_nxt  = stable ? sync_r[2] : lvl_r;
      rise     = stable && sync_r[2] && !lvl_r;
      fall     = stable && !sync_r[2] && lvl_r;
      edge_hit = (rise && mode_r[`CCM_M_RISE]) ||
                 (fall && mode_r[`CCM_M_FALL]);
   end

   //------------------------------------------------------------
   // Register and channel next state
   //------------------------------------------------------------
   // Hardware events come after software strobes so a set beats a clear
   always_comb
   begin
      mode_nxt = mode_r;
      pwm_nxt  = pwm_r;
      cpl_nxt  = cpl_r;
      cph_nxt  = cph_r;
      rll_nxt  = rll_r;
      rlh_nxt  = rlh_r;
      ev_nxt   = ev_r;
      ovf_nxt  = ovf_r;
      out_nxt  = out_r;
      if (i_sfr.wr_mode)
         mode_nxt = i_sfr.data;
      if (i_sfr.wr_pwm)
         pwm_nxt = i_sfr.data;
      if (i_sfr.wr_low)
      begin
         if (view)
            rll_nxt = i_sfr.data;
         else
         begin
            cpl_nxt = i_sfr.data;
            mode_nxt[`CCM_M_ECOM] = 1'b0;
         end
      end
      if (i_sfr.wr_high)
      begin
         if (view)
            rlh_nxt = i_sfr.data;
         else
         begin
            cph_nxt = i_sfr.data;
            mode_nxt[`CCM_M_ECOM] = 1'b1;
         end
      end
      if (i_sfr.clr_event)
         ev_nxt = 1'b0;
      if (i_sfr.clr_ovf)
         ovf_nxt = 1'b0;
      // Short overflow flag is shared and always set on bit N overflow
      if (ovf_n)
         ovf_nxt = 1'b1;
      case (mode_sel)
         CCM_CAPT:
            if (edge_hit)
            begin
               cpl_nxt = i_count[7:0];
               cph_nxt = i_count[15:8];
               ev_nxt  = 1'b1;
            end
         CCM_TIMER:
            if (ecom && full_match)
               ev_nxt = 1'b1;
         CCM_HSO:
            if (ecom && full_match)                            // Hold when off
            begin
               out_nxt = !out_r;
               if (mode_r[`CCM_M_MATCH])
                  ev_nxt = 1'b1;
            end
         CCM_FREQ:
         begin
            if (ecom && low_match)                             // Hold when off
            begin
               out_nxt = !out_r;
               cpl_nxt = freq_sum;
            end
            if (ecom && mode_r[`CCM_M_MATCH] && full_match)
               ev_nxt = 1'b1;
         end
         CCM_PWM8:
         begin
            if (low_match)
            begin
               out_nxt = 1'b1;
               if (mode_r[`CCM_M_MATCH] && ecom)
                  ev_nxt = 1'b1;
            end
            if (ovf8)
            begin
               out_nxt = 1'b0;
               cpl_nxt = cph_r;
            end
            if (!ecom)
               out_nxt = 1'b0;
         end
         CCM_PWM_ENABLE:
         begin
            if (n_match)
            begin
               out_nxt = 1'b1;
               if (mode_r[`CCM_M_MATCH] && ecom)
                  ev_nxt = 1'b1;
            end
            if (ovf_n)
            begin
               out_nxt = 1'b0;
               cpl_nxt = rll_r;
               cph_nxt = rlh_r;
            end
            if (!ecom)
               out_nxt = 1'b0;
         end
         CCM_PWM16:
         begin
            if (full_match)
            begin
               out_nxt = 1'b1;
               if (mode_r[`CCM_M_MATCH] && ecom)
                  ev_nxt = 1'b1;
            end
            if (ovf16)
               out_nxt = 1'b0;
            if (!ecom)
               out_nxt = 1'b0;
         end
         default:
            out_nxt = out_r;
      endcase
   end

   // State registers
   always_ff @(posedge i_clock)
   begin
      if (!i_rstn)
      begin
         mode_r <= `CCM_BYTE_RST;
         pwm_r  <= `CCM_BYTE_RST;
         cpl_r  <= `CCM_BYTE_RST;
         cph_r  <= `CCM_BYTE_RST;
         rll_r  <= `CCM_BYTE_RST;
         rlh_r  <= `CCM_BYTE_RST;
         ev_r   <= 1'b0;
         ovf_r  <= 1'b0;
         out_r  <= 1'b0;
         sync_r <= 3'h0;
         lvl_r  <= 1'b0;
      end
      else
      begin
         mode_r <= mode_nxt;
         pwm_r  <= {pwm_nxt[7], ovf_nxt, pwm_nxt[5:0]};
         cpl_r  <= cpl_nxt;
         cph_r  <= cph_nxt;
         rll_r  <= rll_nxt;
         rlh_r  <= rlh_nxt;
         ev_r   <= ev_nxt;
         ovf_r  <= ovf_nxt;
         out_r  <= out_nxt;
         sync_r <= sync_nxt;
         lvl_r  <= lvl_nxt;
      end
   end

   //------------------------------------------------------------
   // Outputs
   //------------------------------------------------------------
   // Line is driven only in modes that produce a waveform
   assign o_io         = out_r;
   assign o_io_oe      = mode_r[`CCM_M_TOG] || mode_r[`CCM_M_PWM];
   assign o_rd.mode    = mode_r;
   assign o_rd.pwm     = pwm_r;
   assign o_rd.low     = view ? rll_r : cpl_r;
   assign o_rd.high    = view ? rlh_r : cph_r;
   assign o_event_flag = ev_r;
   assign o_ovf_flag   = ovf_r;
   assign o_irq        = (ev_r && mode_r[`CCM_M_IRQ]) ||
                         (ovf_r && pwm_r[`CCM_P_OVIE]);

   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rstn);

   capture_load_a: assert property (mode_sel == CCM_CAPT && edge_hit && quiet |=>
      {cph_r, cpl_r} == $past(i_count) && ev_r)
      else $error("capture did not load counter");
   edge_select_a: assert property (mode_sel == CCM_CAPT && rise && !mode_r[`CCM_M_RISE]
      && !ev_r && !i_sfr.wr_low && quiet |=> !ev_r)
      else $error("rising edge captured while disabled");
   flag_sticky_a: assert property (ev_r && !i_sfr.clr_event |=> ev_r)
      else $error("event flag cleared by hardware");
   irq_raise_a: assert property (ev_r && mode_r[`CCM_M_IRQ] |-> o_irq)
      else $error("interrupt missing with flag set");
   sync_filter_a: assert property ($changed(lvl_r) |-> $past(sync_r[1]) == $past(sync_r[2]))
      else $error("edge accepted before stages agree");
   ecom_clear_a: assert property (i_sfr.wr_low && !view && !i_sfr.wr_high |=> !ecom)
      else $error("low byte write kept comparator on");
   ecom_set_a: assert property (i_sfr.wr_high && !view && !i_sfr.wr_mode |=> ecom)
      else $error("high byte write left comparator off");
   hso_toggle_a: assert property (mode_sel == CCM_HSO && ecom && full_match |=>
      o_io != $past(o_io))
      else $error("high speed output did not toggle");
   hso_hold_a: assert property (mode_sel == CCM_HSO && !ecom |=> o_io == $past(o_io))
      else $error("high speed output moved while off");
   pwm_off_a: assert property (mode_r[`CCM_M_PWM] && !mode_r[`CCM_M_TOG] && !ecom
      |=> !o_io)
      else $error("PWM output high with comparator off");
   freq_add_a: assert property (mode_sel == CCM_FREQ && ecom && low_match && quiet
      |=> cpl_r == $past(freq_sum) && o_io != $past(o_io))
      else $error("frequency step wrong");
   pwm8_reload_a: assert property (mode_sel == CCM_PWM8 && ovf8 && quiet |=>
      cpl_r == $past(cph_r) && !o_io)
      else $error("8-bit PWM reload or low drive missing");
   pwm_enable_reload_a: assert property (mode_sel == CCM_PWM_ENABLE && ovf_n && quiet |=>
      cmp == $past({rlh_r, rll_r}) && !o_io)
      else $error("N-bit PWM reload missing");
   ovf_set_a: assert property (ovf_n |=> ovf_r ##0 pwm_r[`CCM_P_OVF])
      else $error("short overflow flag not set");

   capture_seen_c: cover property (mode_sel == CCM_CAPT && edge_hit ##1 ev_r);
   hso_seen_c: cover property (mode_sel == CCM_HSO && ecom && full_match);
   pwm8_seen_c: cover property (mode_sel == CCM_PWM8 && ecom && low_match ##[1:300] ovf8);
   freq_seen_c: cover property (mode_sel == CCM_FREQ && ecom && low_match);
endmodule : ccm_channel
`default_nettype wire

// ### inc/ccm_params.svh
// Constants for the counter array capture/compare channel
//------------------------------------------------------------
//------------------------------------------------------------
`ifndef CCM_PARAMS_SVH
`define CCM_PARAMS_SVH
// Channel mode register fields
`define CCM_M_WIDE    7
`define CCM_M_ECOM    6
`define CCM_M_RISE    5
`define CCM_M_FALL    4
`define CCM_M_MATCH   3
`define CCM_M_TOG     2
`define CCM_M_PWM     1
`define CCM_M_IRQ     0
// Cycle control register fields
`define CCM_P_VIEW    7
`define CCM_P_OVF     6
`define CCM_P_OVIE    5
`define CCM_P_LEN_HI  1
`define CCM_P_LEN_LO  0
// Reset values and patterns
`define CCM_BYTE_RST  8'h00
`define CCM_WORD_RST  16'h0000
`define CCM_BYTE_ONES 8'hFF
`define CCM_WORD_ONES 16'hFFFF
`define CCM_LEN_8     2'h0
`define CCM_LEN_9     2'h1
`define CCM_LEN_10    2'h2
`define CCM_MASK_8    16'h00FF
`define CCM_MASK_9    16'h01FF
`define CCM_MASK_10   16'h03FF
`define CCM_MASK_11   16'h07FF
`endif

// ### inc/ccm_pkg.sv
// Types shared by the counter array capture/compare channel
`default_nettype none
package ccm_pkg;
   // Special function register write strobes with their data byte
   typedef struct packed {
      logic       wr_mode;
      logic       wr_pwm;
      logic       wr_low;
      logic       wr_high;
      logic       clr_event;
      logic       clr_ovf;
      logic [7:0] data;
   } ccm_sfr_t;
   // Read-back values of the channel registers
   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] pwm;
      logic [7:0] low;
      logic [7:0] high;
   } ccm_rd_t;
   // Decoded channel operating mode
   typedef enum logic [2:0] {
      CCM_IDLE, CCM_CAPT, CCM_TIMER, CCM_HSO, CCM_FREQ, CCM_PWM8, CCM_PWM_ENABLE, CCM_PWM16
   } ccm_mode_t;
endpackage : ccm_pkg
`default_nettype wire

// ### test/ccm_count_model.sv
// Behavioural model of the shared counter that feeds the channel
`timescale 1ns/10ps
`default_nettype none
module ccm_count_model
(
   input  wire logic        i_clock,
   input  wire logic        i_rstn,
   input  wire logic        i_run,
   input  wire logic        i_load,
   input  wire logic [15:0] i_load_val,
   output logic [15:0]      o_count,
   output logic             o_count_en
);
   //------------------------------------------------------------
   // Counter
   //------------------------------------------------------------
   // Counter clock runs at system rate, so the enable is level while running
   assign o_count_en = i_run;
   // Load wins so a test can park the count just short of a match
   always_ff @(posedge i_clock)
   begin
      if (!i_rstn)
         o_count <= 16'h0000;
      else if (i_load)
         o_count <= i_load_val;
      else if (i_run)
         o_count <= o_count + 16'h0001;   // Wraps FFFF to 0000
   end
endmodule : ccm_count_model
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the capture/compare channel
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import ccm_pkg::*;
   localparam logic [5:0] wm = 6'h20, wp = 6'h10, wl = 6'h08, wh = 6'h04, ce = 6'h02, co = 6'h01;
   logic        clk, rstn, run, ld, io_in, io, oe, ev, ovf, irq, cnt_en;
   logic [15:0] lv, cnt, mk;
   ccm_sfr_t    sfr;
   ccm_rd_t     rd;
   int          fail_count, checks, n;

   //------------------------------------------------------------
   // Instances
   //------------------------------------------------------------
   ccm_count_model ccm_count_model_inst (.i_clock(clk), .i_rstn(rstn), .i_run(run),
      .i_load(ld), .i_load_val(lv), .o_count(cnt), .o_count_en(cnt_en));
   ccm_channel ccm_channel_inst (.i_clock(clk), .i_rstn(rstn), .i_count(cnt),
      .i_count_en(cnt_en), .i_sfr(sfr), .i_io(io_in), .o_io(io), .o_io_oe(oe), .o_rd(rd),
      .o_event_flag(ev), .o_ovf_flag(ovf), .o_irq(irq));

   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One register write; strobe dropped a cycle later so back-to-back calls never collide
   task automatic wr(input logic [5:0] s, input logic [7:0] d);
      @(posedge clk);
      sfr <= {s, d};
      @(posedge clk);
      sfr <= '0;
   endtask : wr
   // Park the counter, then let it run from the next edge
   task automatic setc(input logic [15:0] v, input logic r);
      @(posedge clk);
      ld <= 1'b1;
      lv <= v;
      run <= 1'b0;
      @(posedge clk);
      ld <= 1'b0;
      run <= r;
   endtask : setc
   // Bounded wait on io (0), event (1) or overflow (2), sampled at falling edges
   task automatic wsig(input int k, input logic lvl);
      logic s;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
         s = k == 0 ? io : (k == 1 ? ev : ovf);
      end
      while (s !== lvl && n < 6000);
      chk("wait", 16'(n < 6000), 16'h0001);
   endtask : wsig
   task automatic test_done();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done

   //------------------------------------------------------------
   // Scenarios
   //------------------------------------------------------------
   task automatic t_capture();
      logic [7:0] m;
      for (int i = 0; i < 3; i++)
      begin
         m = i == 0 ? 8'h20 : (i == 1 ? 8'h10 : 8'h30);
         wr(wm, m | 8'h01);
         setc(16'(16'h1100 + i), 1'b0);
         io_in <= 1'b1;   // Held 8 clocks
         repeat (8) @(posedge clk);
         @(negedge clk);
         chk("cap rise", 16'(ev), 16'(m[5]));
         chk("cap irq", 16'(irq), 16'(m[5]));
         if (m[5]) chk("cap val", {rd.high, rd.low}, 16'(16'h1100 + i));
         repeat (6) @(negedge clk);
         chk("cap hold", 16'(ev), 16'(m[5]));
         wr(ce, 8'h00);
         setc(16'(16'h2200 + i), 1'b0);
         io_in <= 1'b0;   // Held 8 clocks
         repeat (8) @(posedge clk);
         @(negedge clk);
         chk("cap fall", 16'(ev), 16'(m[4]));
         if (m[4]) chk("cap val2", {rd.high, rd.low}, 16'(16'h2200 + i));
         wr(ce, 8'h00);
         @(negedge clk);
         chk("cap clear", 16'(ev), 16'h0000);
      end
      $display("capture test done");
   endtask : t_capture
   task automatic t_timer_hso();
      wr(wm, 8'h09);
      wr(wl, 8'h34);
      wr(wh, 8'h12);
      @(negedge clk);
      chk("tmr mode", 16'(rd.mode), 16'h0049);
      setc(16'h1230, 1'b1);
      wsig(1, 1'b1);
      chk("tmr cnt", cnt, 16'h1235);
      chk("tmr irq", 16'(irq), 16'h0001);
      wr(ce, 8'h00);
      wr(wm, 8'h4D);
      wr(wl, 8'h00);
      @(negedge clk);
      chk("hso low", 16'(rd.mode), 16'h000D);
      wr(wh, 8'h20);
      @(negedge clk);
      chk("hso high", 16'(rd.mode), 16'h004D);
      chk("hso oe", 16'(oe), 16'h0001);
      setc(16'h1FFD, 1'b1);
      wsig(0, 1'b1);
      chk("hso cnt", cnt, 16'h2001);
      chk("hso ev", 16'(ev), 16'h0001);
      wr(wm, 8'h0D);
      wr(ce, 8'h00);
      setc(16'h1FFD, 1'b1);
      repeat (8) @(negedge clk);
      chk("hso held", 16'(io), 16'h0001);
      chk("hso no ev", 16'(ev), 16'h0000);
      $display("timer and toggle test done");
   endtask : t_timer_hso
   task automatic t_freq();
      logic [7:0] g;
      logic       lvl;
      for (int i = 0; i < 2; i++)
      begin
         g = i == 0 ? 8'h20 : 8'h00;
         setc(16'h0000, 1'b0);
         wr(wm, i == 0 ? 8'h06 : 8'h0E);   // Second pass also enables match flag
         wr(wl, 8'h10);
         wr(wh, g);
         setc(16'h000C, 1'b1);
         @(negedge clk);
         lvl = io;
         wsig(0, ~lvl);
         chk("frq add", 16'(rd.low), 16'(8'(8'h10 + g)));
         wsig(0, lvl);
         chk("frq gap", 16'(n), g == 8'h00 ? 16'h0100 : 16'(g));
         chk("frq ev", 16'(ev), 16'(i));
      end
      $display("frequency test done");
   endtask : t_freq
   task automatic t_pwm();
      setc(16'h0000, 1'b0);
      wr(wp, 8'h00);
      wr(wm, 8'h0B);
      wr(wl, 8'h80);
      wr(wh, 8'hC0);
      wr(ce | co, 8'h00);
      setc(16'h00FD, 1'b1);
      wsig(2, 1'b1);
      chk("p8 ovf", cnt, 16'h0100);
      chk("p8 low", 16'(io), 16'h0000);
      chk("p8 copy", 16'(rd.low), 16'h00C0);
      wr(co, 8'h00);
      wsig(0, 1'b1);
      chk("p8 match", cnt, 16'h01C1);
      chk("p8 ev", 16'(ev), 16'h0001);
      wsig(2, 1'b1);
      chk("p8 period", cnt, 16'h0200);
      for (int len = 1; len < 4; len++)
      begin
         mk = 16'((1 << (8 + len)) - 1);
         setc(16'h0000, 1'b0);
         wr(wm, 8'h02);
         wr(wp, 8'(8'h80 | len));
         wr(wl, 8'h05);
         wr(wh, 8'h00);
         @(negedge clk);
         chk("pn view", 16'(rd.mode), 16'h0002);
         wr(wp, 8'(8'h20 | len));
         wr(wm, 8'h42);
         wr(co, 8'h00);
         setc(16'(mk - 2), 1'b1);
         wsig(2, 1'b1);
         chk("pn ovf", cnt, 16'(mk + 1));
         chk("pn low", 16'(io), 16'h0000);
         chk("pn load", {rd.high, rd.low}, 16'h0005);
         chk("pn flag", 16'(rd.pwm), 16'(8'h60 | len));
         chk("pn irq", 16'(irq), 16'h0001);
         wsig(0, 1'b1);
         chk("pn match", cnt & mk, 16'h0006);
      end
      setc(16'h0000, 1'b0);
      wr(wp, 8'h03);
      wr(wm, 8'h82);
      wr(wl, 8'h34);
      wr(wh, 8'h12);
      @(negedge clk);
      chk("p16 mode", 16'(rd.mode), 16'h00C2);
      // Line starts low, so raise it by a match before looking for the overflow
      setc(16'h1230, 1'b1);
      wsig(0, 1'b1);
      chk("p16 match", cnt, 16'h1235);
      setc(16'hFFFD, 1'b1);
      wsig(0, 1'b0);
      chk("p16 ovf", cnt, 16'h0000);
      setc(16'h1233, 1'b1);
      wsig(0, 1'b1);
      wr(wm, 8'h82);
      repeat (2) @(negedge clk);
      chk("p16 off", 16'(io), 16'h0000);
      $display("pwm test done");
   endtask : t_pwm

   //------------------------------------------------------------
   // Clock, reset, sequence and watchdog
   //------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      rstn = 1'b0;
      run = 1'b0;
      ld = 1'b0;
      lv = 16'h0000;
      io_in = 1'b0;
      sfr = '0;
      fail_count = 0;
      checks = 0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      chk("rst regs", {rd.mode, rd.pwm}, 16'h0000);
      chk("rst cmp", {rd.low, rd.high}, 16'h0000);
      chk("rst outs", 16'({io, oe, ev, ovf, irq}), 16'h0000);
      t_capture();
      t_timer_hso();
      t_freq();
      t_pwm();
      test_done();
   end
   // Whole run needs under 10000 clocks; twice that means a hang
   initial
   begin
      #1000000;
      fail_count++;
      test_done();
   end
endmodule : tb_top
`default_nettype wire
